//--- dmd_consts.svh
// constants for the data-space memory map decoder
// Overview of operation
// - program, data and io are separate 64k spaces of 16-bit words
// - top 256 to 32k data words are global memory, sized by allocation register
// - global accesses wait for the global bus request grant before proceeding
// - data 0 to 5fh decode only to cpu registers or reserved
// - peripheral registers are reached only through data-space decoding
// - frame one holds system and peripheral registers except event manager
// - capture and quadrature encoder registers sit at data 7420h to 7426h
`ifndef DMD_CONSTS_SVH
`define DMD_CONSTS_SVH
`define DMD_GLOBAL_REGION_SIZE_ADDR   16'h0005
`define DMD_GLOBAL_REGION_SIZE_RST    16'h0000
`define DMD_MMR_LAST    16'h005F
`define DMD_B2_FIRST    16'h0060
`define DMD_B2_LAST     16'h007F
`define DMD_B0_FIRST    16'h0200
`define DMD_B0_LAST     16'h02FF
`define DMD_B1_FIRST    16'h0300
`define DMD_B1_LAST     16'h03FF
`define DMD_PF1_FIRST   16'h7000
`define DMD_PF1_LAST    16'h73FF
`define DMD_PF2_FIRST   16'h7400
`define DMD_PF2_LAST    16'h743F
`define DMD_CAP_FIRST   16'h7420
`define DMD_CAP_LAST    16'h7426
`define DMD_ILL_FIRST   16'h0800
`define DMD_ILL_LAST    16'h6FFF
`define DMD_ILL2_FIRST  16'h7800
`define DMD_ILL2_LAST   16'h7FFF
`endif

//--- dmd_pkg.sv
// types for the data-space memory map decoder
package dmd_pkg;
  typedef enum logic [1:0] {
    DMD_SP_PROG,
    DMD_SP_DATA,
    DMD_SP_IO
  } dmd_space_t;
  typedef enum logic [3:0] {
    DMD_T_NONE,
    DMD_T_MMR,
    DMD_T_RESERVED,
    DMD_T_ILLEGAL,
    DMD_T_B2,
    DMD_T_B0,
    DMD_T_B1,
    DMD_T_PF1,
    DMD_T_PF2,
    DMD_T_CAPQEP,
    DMD_T_GLOBAL,
    DMD_T_EXTERNAL,
    DMD_T_PROG,
    DMD_T_IO
  } dmd_target_t;
  typedef enum {DMD_IDLE, DMD_WAIT} dmd_state_t;
endpackage : dmd_pkg

//--- dmd_decoder.sv
// memory map decoder between cpu core and address spaces
`timescale 1ns/10ps
`include "dmd_consts.svh"
module dmd_decoder (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  // cpu request
  input  wire logic              req_i,
  input  wire logic              write_i,
  input  wire dmd_pkg::dmd_space_t space_i,
  input  wire logic [15:0]       addr_i,
  input  wire logic [15:0]       wdata_i,
  // configuration and global bus
  input  wire logic              block0_space_select_i,
  input  wire logic              global_bus_grant_i,
  // decoded access
  output logic                   valid_o,
  output dmd_pkg::dmd_target_t   target_o,
  output logic [15:0]            offset_o,
  output logic                   write_o,
  output logic [15:0]            wdata_o,
  output logic                   global_bus_request_o,
  output logic [15:0]            global_region_size_o,
  output logic                   busy_o
);
  import dmd_pkg::*;

  typedef struct packed {
    dmd_state_t  state;
    // two-stage synchronisers for the pin inputs
    logic        sel_s1;
    logic        sel_s2;
    logic        gnt_s1;
    logic        gnt_s2;
    // allocation register
    logic [15:0] global_region_size;
    // decoded access as seen by the far side
    logic        valid;
    dmd_target_t target;
    logic [15:0] offset;
    logic        write;
    logic [15:0] wdata;
    logic        breq;
    // global access parked while the grant is awaited
    logic [15:0] p_addr;
    logic        p_write;
    logic [15:0] p_wdata;
  } dmd_st_t;

  dmd_st_t st_reg;
  dmd_st_t st_next;
  logic [15:0] gmask;
  logic        in_global;
  dmd_target_t dtgt;
  logic [15:0] doff;

  // allocation register picks a power-of-two region at the top of data
  // space; values that are not one of the eight sizes fall back to 256
  // words, so a stray write can never open a region wider than 32k
  always_comb begin
    case (st_reg.global_region_size[15:8])
      8'hFF:   gmask = 16'hFF00;
      8'hFE:   gmask = 16'hFE00;
      8'hFC:   gmask = 16'hFC00;
      8'hF8:   gmask = 16'hF800;
      8'hF0:   gmask = 16'hF000;
      8'hE0:   gmask = 16'hE000;
      8'hC0:   gmask = 16'hC000;
      8'h80:   gmask = 16'h8000;
      default: gmask = 16'hFF00;
    endcase
  end

  assign in_global = ((addr_i & gmask) == gmask);

  // data-space decode, fixed regions first, global overlay last;
  // gaps between blocks are reserved, illegal ranges are passed on
  // so the cpu side can trap them
  always_comb begin
    dtgt = DMD_T_EXTERNAL;
    doff = addr_i;
    if (addr_i <= `DMD_MMR_LAST) begin
      case (addr_i[6:0])
        7'h04,
        7'h05,
        7'h06:   dtgt = DMD_T_MMR;
        default: dtgt = DMD_T_RESERVED;
      endcase
    end else if (addr_i <= `DMD_B2_LAST) begin
      dtgt = DMD_T_B2;
      doff = addr_i - `DMD_B2_FIRST;
    end else if (addr_i < `DMD_B0_FIRST) begin
      dtgt = DMD_T_RESERVED;
    end else if (addr_i <= `DMD_B0_LAST) begin
      dtgt = st_reg.sel_s2 ? DMD_T_RESERVED : DMD_T_B0;
      doff = addr_i - `DMD_B0_FIRST;
    end else if (addr_i <= `DMD_B1_LAST) begin
      dtgt = DMD_T_B1;
      doff = addr_i - `DMD_B1_FIRST;
    end else if (addr_i < `DMD_ILL_FIRST) begin
      dtgt = DMD_T_RESERVED;
    end else if (addr_i <= `DMD_ILL_LAST) begin
      dtgt = DMD_T_ILLEGAL;
    end else if (addr_i <= `DMD_PF1_LAST) begin
      dtgt = DMD_T_PF1;
      doff = addr_i - `DMD_PF1_FIRST;
    end else if (addr_i >= `DMD_CAP_FIRST && addr_i <= `DMD_CAP_LAST) begin
      dtgt = DMD_T_CAPQEP;
      doff = addr_i - `DMD_CAP_FIRST;
    end else if (addr_i <= `DMD_PF2_LAST) begin
      dtgt = DMD_T_PF2;
      doff = addr_i - `DMD_PF2_FIRST;
    end else if (addr_i < `DMD_ILL2_FIRST) begin
      dtgt = DMD_T_RESERVED;
    end else if (addr_i <= `DMD_ILL2_LAST) begin
      dtgt = DMD_T_ILLEGAL;
    end

    // the overlay wins, whatever fixed region lies beneath it
    if (in_global) begin
      dtgt = DMD_T_GLOBAL;
      doff = addr_i & ~gmask;
    end
  end

  // synchronisers first, then request capture; only idle takes a request
  always_comb begin
    st_next        = st_reg;
    st_next.sel_s1 = block0_space_select_i;
    st_next.sel_s2 = st_reg.sel_s1;
    st_next.gnt_s1 = global_bus_grant_i;
    st_next.gnt_s2 = st_reg.gnt_s1;
    // valid is a single-cycle pulse
    st_next.valid  = 1'b0;
    case (st_reg.state)
      DMD_IDLE: begin
        if (req_i) begin
          st_next.write  = write_i;
          st_next.wdata  = wdata_i;
          st_next.offset = addr_i;
          case (space_i)
            DMD_SP_PROG: begin
              st_next.valid  = 1'b1;
              st_next.target = DMD_T_PROG;
            end
            DMD_SP_IO: begin
              st_next.valid  = 1'b1;
              st_next.target = DMD_T_IO;
            end
            default: begin
              // park the access; it is replayed once the grant is seen
              if (dtgt == DMD_T_GLOBAL) begin
                st_next.state   = DMD_WAIT;
                st_next.breq    = 1'b1;
                st_next.target  = DMD_T_GLOBAL;
                st_next.offset  = doff;
                st_next.p_addr  = addr_i;
                st_next.p_write = write_i;
                st_next.p_wdata = wdata_i;
              end else begin
                st_next.valid  = 1'b1;
                st_next.target = dtgt;
                st_next.offset = doff;
                // register write is also reported as a cpu register access
                if (write_i && addr_i == `DMD_GLOBAL_REGION_SIZE_ADDR)
                  st_next.global_region_size = wdata_i;
              end
            end
          endcase
        end
      end

      // request stays up until the synchronised grant arrives
      DMD_WAIT: begin
        if (st_reg.gnt_s2) begin
          st_next.valid  = 1'b1;
          st_next.breq   = 1'b0;
          st_next.state  = DMD_IDLE;
          st_next.offset = st_reg.p_addr & ~gmask;
          st_next.write  = st_reg.p_write;
          st_next.wdata  = st_reg.p_wdata;
        end
      end

      default: st_next.state = DMD_IDLE;
    endcase
  end

  // every field to a constant, so the reset branch stays purely constant
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg.sel_s1  <= 1'b0;
      st_reg.sel_s2  <= 1'b0;
      st_reg.gnt_s1  <= 1'b0;
      st_reg.gnt_s2  <= 1'b0;
      st_reg.valid   <= 1'b0;
      st_reg.offset  <= 16'h0000;
      st_reg.write   <= 1'b0;
      st_reg.wdata   <= 16'h0000;
      st_reg.breq    <= 1'b0;
      st_reg.p_addr  <= 16'h0000;
      st_reg.p_write <= 1'b0;
      st_reg.p_wdata <= 16'h0000;
      st_reg.state  <= DMD_IDLE;
      st_reg.global_region_size   <= `DMD_GLOBAL_REGION_SIZE_RST;
      st_reg.target <= DMD_T_NONE;
    end else begin
      st_reg <= st_next;
    end
  end


  // decoded access
  assign valid_o              = st_reg.valid;
  assign target_o             = st_reg.target;
  assign offset_o             = st_reg.offset;
  assign write_o              = st_reg.write;
  assign wdata_o              = st_reg.wdata;
  // global bus and register view
  assign global_bus_request_o = st_reg.breq;
  assign global_region_size_o = st_reg.global_region_size;
  assign busy_o               = (st_reg.state == DMD_WAIT);
endmodule : dmd_decoder

//--- dmd_chk_sva.sv
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module dmd_chk (
  input wire logic                 clock_i,
  input wire logic                 arst_n_i,
  input wire logic                 req_i,
  input wire dmd_pkg::dmd_space_t  space_i,
  input wire logic [15:0]          addr_i,
  input wire logic                 block0_space_select_i,
  input wire logic                 global_bus_grant_i,
  input wire logic                 valid_o,
  input wire dmd_pkg::dmd_target_t target_o,
  input wire logic                 global_bus_request_o,
  input wire logic                 busy_o
);
  import dmd_pkg::*;
  logic       tk;
  logic [3:0] sh;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  assign tk = req_i && !busy_o && space_i == DMD_SP_DATA;
  // select history, as the decoder sees it through a synchroniser
  always_ff @(posedge clock_i) sh <= {sh[2:0], block0_space_select_i};
  prog_space_a: assert property (
    req_i && !busy_o && space_i == DMD_SP_PROG |=>
    valid_o && target_o == DMD_T_PROG) else $error("prog decode");
  low_regs_a: assert property (tk && addr_i <= 16'h005F |=>
    target_o inside {DMD_T_MMR, DMD_T_RESERVED}) else $error("low regs");
  capture_win_a: assert property (
    tk && addr_i inside {[16'h7420:16'h7426]} |=>
    target_o == DMD_T_CAPQEP) else $error("capture window");
  block0_ram_a: assert property (
    tk && addr_i[15:8] == 8'h02 && sh == 4'h0 |=>
    target_o == DMD_T_B0) else $error("block zero ram");
  block0_rsv_a: assert property (
    tk && addr_i[15:8] == 8'h02 && sh == 4'hF |=>
    target_o == DMD_T_RESERVED) else $error("block zero reserved");
  global_req_a: assert property (tk && addr_i >= 16'hFF00 |=>
    global_bus_request_o && busy_o && !valid_o) else $error("no request");
  grant_first_a: assert property ($fell(busy_o) |->
    valid_o && $past(global_bus_grant_i, 2)) else $error("early access");
  grant_done_a: assert property (
    $rose(global_bus_grant_i) && busy_o |-> ##[1:5] valid_o)
    else $error("grant ignored");
endmodule : dmd_chk
bind dmd_decoder dmd_chk chk (.*);

//--- dmd_arb_model.sv
// global bus arbiter model facing the decoder
`timescale 1ns/10ps
module dmd_arb (
  input  wire logic clock_i,
  input  wire logic slow_i,
  input  wire logic req_i,
  output logic      grant_o
);
  int n = 0;
  initial grant_o = 1'b0;
  // grant once the request has stood a while, drop it with it
  always @(posedge clock_i) begin
    #1;
    n = req_i ? n + 1 : 0;
    grant_o = n > (slow_i ? 8 : 1);
  end
endmodule : dmd_arb

//--- tb_dmd_decoder.sv
// self-checking bench for the memory map decoder
`timescale 1ns/10ps
module tb_dmd_decoder;
  import dmd_pkg::*;
  logic        clock_i = 0, arst_n_i, req_i = 0, write_i = 0;
  logic        write_o;
  logic [15:0] offset_o, wdata_o;
  logic        block0_space_select_i = 0, global_bus_grant_i, slow = 0;
  logic        valid_o, global_bus_request_o, busy_o;
  logic [15:0] addr_i = 16'h0000, wdata_i = 16'hF000, global_region_size_o;
  dmd_space_t  space_i = DMD_SP_PROG;
  dmd_target_t target_o;
  int          err_total = 0, total_checks = 0;
  always #5 clock_i = ~clock_i;
  dmd_decoder dut (.*);
  dmd_arb arb (.clock_i, .slow_i(slow), .req_i(global_bus_request_o),
               .grant_o(global_bus_grant_i));
  task automatic chk(input logic [15:0] a, s, e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] addr %h exp %h seen %h", a, e, s);
    end
  endtask : chk
  task automatic acc(input dmd_space_t s, input logic w,
                     input logic [15:0] a, input dmd_target_t e);
    int n;
    @(posedge clock_i);
    #1;
    {req_i, write_i, space_i, addr_i} = {1'b1, w, s, a};
    @(posedge clock_i);
    #1;
    req_i = 0;
    for (n = 0; n < 40 && valid_o !== 1'b1; n++) @(posedge clock_i) #1;
    chk(a, {12'h000, target_o}, {12'h000, e});
  endtask : acc
  task automatic d(input logic [15:0] a, input dmd_target_t e);
    acc(DMD_SP_DATA, 1'b0, a, e);
  endtask : d
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    #200000;
    err_total++;
    test_done;
  end
  initial begin
    arst_n_i = 0;
    repeat (16) @(posedge clock_i);
    #1 arst_n_i = 1;
    chk(16'h0005, global_region_size_o, 16'h0000);
    acc(DMD_SP_PROG, 1'b1, 16'h0200, DMD_T_PROG);
    acc(DMD_SP_IO, 1'b0, 16'hFFFF, DMD_T_IO);
    d(16'h0005, DMD_T_MMR);
    d(16'h005F, DMD_T_RESERVED);
    d(16'h0060, DMD_T_B2);
    d(16'h7010, DMD_T_PF1);
    d(16'h7090, DMD_T_PF1);
    d(16'h7400, DMD_T_PF2);
    d(16'h7420, DMD_T_CAPQEP);
    d(16'h7426, DMD_T_CAPQEP);
    chk(16'h7426, offset_o, 16'h0006);
    $display("test map done");
    d(16'h0200, DMD_T_B0);
    block0_space_select_i = 1;
    repeat (4) @(posedge clock_i);
    d(16'h02FF, DMD_T_RESERVED);
    d(16'h0300, DMD_T_B1);
    chk(16'h0300, offset_o, 16'h0000);
    $display("test block zero done");
    d(16'hFF00, DMD_T_GLOBAL);
    d(16'hFEFF, DMD_T_EXTERNAL);
    acc(DMD_SP_DATA, 1'b1, 16'h0005, DMD_T_MMR);
    chk(16'h0005, {15'h0000, write_o}, 16'h0001);
    chk(16'h0005, wdata_o, 16'hF000);
    slow = 1;
    d(16'hF000, DMD_T_GLOBAL);
    chk(16'hF000, offset_o, 16'h0000);
    chk(16'hF000, {15'h0000, write_o}, 16'h0000);
    chk(16'h0005, global_region_size_o, 16'hF000);
    d(16'hEFFF, DMD_T_EXTERNAL);
    $display("test global done");
    test_done;
  end
endmodule : tb_dmd_decoder
